// ### verilog/hbs_pkg.sv
package hbs_pkg;

   // Register map of the plain register port, byte addresses.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] ADDR_DELAY = 8'h00;
   localparam logic [7:0] ADDR_SPEED_THR = 8'h04;
   localparam logic [7:0] ADDR_WAIT = 8'h08;
   localparam logic [7:0] ADDR_ASSIGN = 8'h0c;
   localparam logic [7:0] ADDR_CMD = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // Setting ranges and reset values.
   localparam int DELAY_W = 6;
   localparam int THR_W = 14;
   localparam int WAIT_W = 7;
   localparam int TERM_W = 2;
   localparam logic [5:0] DELAY_MAX = 6'h32;
   localparam logic [5:0] DELAY_RST = 6'h00;
   localparam logic [13:0] THR_MAX = 14'h2710;
   localparam logic [13:0] THR_RST = 14'h0064;
   localparam logic [6:0] WAIT_MIN = 7'h0a;
   localparam logic [6:0] WAIT_MAX = 7'h64;
   localparam logic [6:0] WAIT_RST = 7'h32;
   localparam logic [1:0] TERM_NONE = 2'h0;
   localparam logic [1:0] TERM_RST = 2'h0;
   localparam int TERM_COUNT = 3;
   localparam int CMD_RESTART_BIT = 0;
   localparam logic [13:0] STOPPED_RPM = 14'h0000;

   // Delay time base: 10 ms steps on a 125 MHz clock.
   localparam int TICK_MS = 10;
   localparam int CLK_PERIOD_NS = 8;
   localparam int TICK_NS = TICK_MS * 1000000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0]
   {
      ST_OFF = 3'b000,
      ST_ON = 3'b001,
      ST_STOP_DLY = 3'b011,
      ST_RUN_WAIT = 3'b010,
      ST_ZS_DECEL = 3'b110
   } hbs_state_t;

   typedef struct packed
   {
      logic [13:0] speed;
      logic [13:0] max_speed;
   } hbs_motor_t;

   typedef struct packed
   {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } hbs_bus_t;

   typedef struct packed
   {
      logic [23:0] zero;
      logic alarm;
      logic overtravel;
      logic servo_on;
      logic power;
      logic brake_release;
      logic [2:0] state;
   } hbs_status_t;

   typedef struct packed
   {
      logic [25:0] zero_hi;
      logic [1:0] active;
      logic [1:0] zero_lo;
      logic [1:0] pending;
   } hbs_assign_rd_t;

endpackage

// ### verilog/hbs_tick.sv
`timescale 1ns/1ps
module hbs_tick #(
   parameter int unsigned CYCLES = hbs_pkg::TICK_CYCLES
)(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic restart,
   output logic tick
);
   import hbs_pkg::*;

   localparam int CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);
   localparam logic [CNT_W-1:0] ZERO = '0;
   localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

   logic [CNT_W-1:0] cnt;

   // Restarting the phase keeps the first step of a delay a full 10 ms.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst || restart || cnt == LAST)
         cnt <= ZERO;
      else
         cnt <= cnt + ONE;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst || restart)
         tick <= 1'b0;
      else
         tick <= (cnt == LAST);
   end

endmodule

// ### verilog/hbs_sequencer.sv
`timescale 1ns/1ps
module hbs_sequencer #(
   parameter int unsigned TICK_CYCLES = hbs_pkg::TICK_CYCLES
)(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire hbs_pkg::hbs_bus_t bus,
   output logic [31:0] rdata,
   input wire logic servo_on_pin,
   input wire logic overtravel_pin,
   input wire logic alarm,
   input wire logic zero_speed_stop,
   input wire hbs_pkg::hbs_motor_t motor,
   output logic motor_power_en,
   output logic brake_release_out,
   output logic [2:0] term_out
);
   import hbs_pkg::*;

   localparam int PIN_N = 2;
   localparam int PIN_SERVO = 0;
   localparam int PIN_OVT = 1;

   hbs_state_t state;
   hbs_state_t next_state;
   logic [DELAY_W-1:0] delay_set;
   logic [THR_W-1:0] thr_set;
   logic [WAIT_W-1:0] wait_set;
   logic [TERM_W-1:0] term_pending;
   logic [TERM_W-1:0] term_active;
   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] pin_f;
   logic servo_on;
   logic overtravel;
   logic stopped;
   logic below_thr;
   logic [THR_W-1:0] eff_thr;
   logic tick;
   logic [WAIT_W-1:0] tick_cnt;
   logic delay_done;
   logic wait_done;
   logic next_brake;
   logic next_power;
   hbs_status_t status;
   hbs_assign_rd_t assign_rd;

   function automatic logic wr_hit(input hbs_bus_t b, input logic [7:0] a);
      wr_hit = b.wr && b.addr == a;
   endfunction

   // Pin inputs: three stages, a change is taken once stages two and three agree.
   assign pin_raw = {overtravel_pin, servo_on_pin};

   generate
      for (genvar i = 0; i < PIN_N; i++)
      begin : g_sync
         logic s1;
         logic s2;
         logic s3;
         always_ff @(posedge sys_clk)
         begin
            if (!nrst)
            begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
               pin_f[i] <= 1'b0;
            end
            else
            begin
               s1 <= pin_raw[i];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3)
                  pin_f[i] <= s3;
            end
         end
      end
   endgenerate

   assign servo_on = pin_f[PIN_SERVO];
   assign overtravel = pin_f[PIN_OVT];

   // Settings registers; out-of-range writes saturate at the nearest limit.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         delay_set <= DELAY_RST;
      else if (wr_hit(bus, ADDR_DELAY))
         delay_set <= (bus.wdata > 32'(DELAY_MAX)) ? DELAY_MAX
                      : bus.wdata[DELAY_W-1:0];
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         thr_set <= THR_RST;
      else if (wr_hit(bus, ADDR_SPEED_THR))
         thr_set <= (bus.wdata > 32'(THR_MAX)) ? THR_MAX
                    : bus.wdata[THR_W-1:0];
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         wait_set <= WAIT_RST;
      else if (wr_hit(bus, ADDR_WAIT))
      begin
         if (bus.wdata < 32'(WAIT_MIN))
            wait_set <= WAIT_MIN;
         else if (bus.wdata > 32'(WAIT_MAX))
            wait_set <= WAIT_MAX;
         else
            wait_set <= bus.wdata[WAIT_W-1:0];
      end
   end

   // The terminal choice is staged and only copied on a restart command,
   // so an assignment write alone never moves a live brake relay between terminals mid-run.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         term_pending <= TERM_RST;
      else if (wr_hit(bus, ADDR_ASSIGN))
         term_pending <= bus.wdata[TERM_W-1:0];
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         term_active <= TERM_NONE;
      else if (wr_hit(bus, ADDR_CMD) && bus.wdata[CMD_RESTART_BIT])
         term_active <= term_pending;
   end

   // Speed comparisons.
   assign eff_thr = (thr_set > motor.max_speed) ? motor.max_speed : thr_set;
   assign below_thr = motor.speed < eff_thr;
   assign stopped = motor.speed <= STOPPED_RPM;

   // Delay timing in 10 ms ticks.
   hbs_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .restart(next_state != state),
      .tick(tick)
   );

   always_ff @(posedge sys_clk)
   begin
      if (!nrst || next_state != state)
         tick_cnt <= '0;
      else if (tick && tick_cnt != WAIT_MAX)
         tick_cnt <= tick_cnt + WAIT_W'(1);
   end

   assign delay_done = tick_cnt >= {1'b0, delay_set};
   assign wait_done = tick_cnt >= wait_set;

   // Sequencing of motor power against the brake.
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_OFF:
         begin
            if (servo_on && !alarm)
               next_state = ST_ON;
         end
         ST_ON:
         begin
            // Overtravel is deliberately not a cause here.
            if (alarm && !stopped && zero_speed_stop)
               next_state = ST_ZS_DECEL;
            else if (alarm && !stopped)
               next_state = ST_RUN_WAIT;
            else if (alarm)
               next_state = ST_OFF;
            else if (!servo_on && !stopped)
               next_state = ST_RUN_WAIT;
            else if (!servo_on && delay_set == DELAY_RST)
               next_state = ST_OFF;
            else if (!servo_on)
               next_state = ST_STOP_DLY;
         end
         ST_STOP_DLY:
         begin
            if (alarm || delay_done)
               next_state = ST_OFF;
            else if (servo_on)
               next_state = ST_ON;
         end
         ST_RUN_WAIT:
         begin
            if (below_thr || wait_done)
               next_state = ST_OFF;
         end
         ST_ZS_DECEL:
         begin
            // At rest under an alarm: stopped timing, delay skipped.
            if (stopped)
               next_state = ST_OFF;
         end
         default:
            next_state = ST_OFF;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         state <= ST_OFF;
      else
         state <= next_state;
   end

   always_comb
   begin
      next_brake = (next_state == ST_ON) || (next_state == ST_RUN_WAIT)
                   || (next_state == ST_ZS_DECEL);
      next_power = (next_state == ST_ON) || (next_state == ST_STOP_DLY)
                   || (next_state == ST_ZS_DECEL);
   end

   // Outputs follow the next state, so the brake drops at the same edge
   // that the state leaves ST_ON for ST_OFF or ST_STOP_DLY.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         brake_release_out <= 1'b0;
         motor_power_en <= 1'b0;
      end
      else
      begin
         brake_release_out <= next_brake;
         motor_power_en <= next_power;
      end
   end

   generate
      for (genvar t = 0; t < TERM_COUNT; t++)
      begin : g_term
         always_ff @(posedge sys_clk)
         begin
            if (!nrst)
               term_out[t] <= 1'b0;
            else
               term_out[t] <= next_brake && term_active == TERM_W'(t + 1);
         end
      end
   endgenerate

   // Register read port: data appear in the cycle after the strobe only.
   always_comb
   begin
      status = '0;
      status.alarm = alarm;
      status.overtravel = overtravel;
      status.servo_on = servo_on;
      status.power = motor_power_en;
      status.brake_release = brake_release_out;
      status.state = state;
      assign_rd = '0;
      assign_rd.active = term_active;
      assign_rd.pending = term_pending;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst || !bus.rd)
         rdata <= '0;
      else
      begin
         unique case (bus.addr)
            ADDR_DELAY: rdata <= 32'(delay_set);
            ADDR_SPEED_THR: rdata <= 32'(thr_set);
            ADDR_WAIT: rdata <= 32'(wait_set);
            ADDR_ASSIGN: rdata <= assign_rd;
            ADDR_STATUS: rdata <= status;
            default: rdata <= '0;
         endcase
      end
   end

   // Checks.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_alarm_brake_off: assert property (
      state == ST_ON && alarm && stopped |=> !brake_release_out && !motor_power_en)
      else $error("brake or power still on after alarm at rest");

   a_overtravel_release: assert property (
      state == ST_ON && overtravel && servo_on && !alarm |=> brake_release_out)
      else $error("overtravel applied the brake");

   a_term_unassigned: assert property (
      term_active == TERM_NONE |=> term_out == '0)
      else $error("terminal driven while unassigned");

   a_stop_brake_now: assert property (
      state == ST_ON && !servo_on && stopped && !alarm
      |=> !brake_release_out && motor_power_en == (delay_set != DELAY_RST))
      else $error("stopped servo-off brake timing wrong");

   a_delay_power_hold: assert property (
      state == ST_STOP_DLY && !delay_done && !alarm && !servo_on
      |=> motor_power_en && !brake_release_out)
      else $error("power removed before delay elapsed");

   a_alarm_power_cut: assert property (
      state == ST_STOP_DLY && alarm |=> !motor_power_en)
      else $error("alarm did not cut power at once");

   a_thr_clamped: assert property (
      eff_thr <= motor.max_speed && eff_thr <= thr_set)
      else $error("effective threshold above maximum speed");

   a_run_wait_exit: assert property (
      state == ST_RUN_WAIT && (below_thr || wait_done)
      |=> !brake_release_out && !motor_power_en)
      else $error("rotating brake apply missed");

   a_zs_decel_hold: assert property (
      state == ST_ZS_DECEL && !stopped |=> motor_power_en && brake_release_out)
      else $error("zero-speed stop released power early");

   a_wait_in_range: assert property (
      wait_set >= WAIT_MIN && wait_set <= WAIT_MAX && delay_set <= DELAY_MAX)
      else $error("setting outside its range");

   a_count_restart: assert property (
      next_state != state |=> tick_cnt == '0)
      else $error("delay count not restarted");

   c_stop_delay: cover property (state == ST_STOP_DLY ##1 state == ST_OFF);
   c_run_wait: cover property (state == ST_RUN_WAIT && wait_done);
   c_zs_decel: cover property (state == ST_ZS_DECEL ##1 state == ST_OFF);

endmodule

// ### tb/hbs_far_side.sv
`timescale 1ns/1ps
module hbs_far_side #(
   parameter int REF_WAIT = 50
)(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic motor_power_en,
   input wire logic brake_release_out,
   input wire logic [13:0] load_speed,
   input wire logic load_stb,
   input wire logic [13:0] decel,
   output logic [13:0] speed,
   output logic brake_relay,
   output logic ref_ok
);
   int held;

   // The relay pulls in one cycle after the release output changes.
   always_ff @(posedge sys_clk)
   begin
      brake_relay <= nrst & brake_release_out;
   end

   // The shaft coasts down only without drive power; an engaged brake holds it at rest.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         speed <= 14'h0000;
      else if (load_stb)
         speed <= load_speed;
      else if (!brake_relay)
         speed <= 14'h0000;
      else if (!motor_power_en)
         speed <= (speed > decel) ? speed - decel : 14'h0000;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst || !brake_relay || !motor_power_en)
         held <= 0;
      else if (held < REF_WAIT)
         held <= held + 1;
   end

   assign ref_ok = (held >= REF_WAIT);
endmodule

// ### tb/hbs_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      n_tests++; \
      if ((a) !== (b)) \
      begin \
         num_errors++; \
         $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); \
      end \
   end
module hbs_sequencer_tb;
   import hbs_pkg::*;
   localparam int TK = 10;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   hbs_bus_t bus = '0;
   logic [31:0] rdata;
   logic servo_on_pin = 1'b0;
   logic overtravel_pin = 1'b0;
   logic alarm = 1'b0;
   logic zero_speed_stop = 1'b0;
   logic [13:0] max_speed = 14'h3fff;
   logic [13:0] load_speed = 14'h0000;
   logic [13:0] decel = 14'h0000;
   logic load_stb = 1'b0;
   logic [13:0] speed;
   hbs_motor_t motor;
   logic motor_power_en;
   logic brake_release_out;
   logic brake_relay;
   logic ref_ok;
   logic [2:0] term_out;
   int num_errors = 0;
   int n_tests = 0;
   int i;
   int n;

   assign motor = {speed, max_speed};
   always #4 sys_clk = ~sys_clk;

   hbs_sequencer #(.TICK_CYCLES(TK)) u_hbs_sequencer (
      .sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
      .servo_on_pin(servo_on_pin), .overtravel_pin(overtravel_pin), .alarm(alarm),
      .zero_speed_stop(zero_speed_stop), .motor(motor), .motor_power_en(motor_power_en),
      .brake_release_out(brake_release_out), .term_out(term_out));

   hbs_far_side #(.REF_WAIT(5 * TK)) u_hbs_far_side (
      .sys_clk(sys_clk), .nrst(nrst), .motor_power_en(motor_power_en),
      .brake_release_out(brake_release_out), .load_speed(load_speed), .load_stb(load_stb),
      .decel(decel), .speed(speed), .brake_relay(brake_relay), .ref_ok(ref_ok));

   task automatic conclude();
      $display("errors %0d comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge sys_clk);
      bus.wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      @(negedge sys_clk);
      `CHK(rdata, e)
      @(posedge sys_clk);
   endtask

   // Waiting is itself the check: a level that never arrives ends the run.
   task automatic wait_sig(input int which, input logic v, input int lim, output int cnt);
      for (cnt = 1; cnt <= lim; cnt++)
      begin
         @(negedge sys_clk);
         if ((which ? motor_power_en : brake_release_out) === v)
            break;
      end
      @(posedge sys_clk);
      n_tests++;
      if (cnt > lim)
      begin
         num_errors++;
         $display("mismatch at %0t: got %0h expected %0h", $time, !v, v);
         conclude();
      end
   endtask

   task automatic servo_up();
      int c;
      servo_on_pin <= 1'b1;
      wait_sig(0, 1'b1, 20, c);
      `CHK(motor_power_en, 1'b1)
   endtask

   task automatic spin(input logic [13:0] v, input logic [13:0] d);
      int k;
      for (k = 0; k < 100 && !ref_ok; k++)
         @(posedge sys_clk);
      `CHK(ref_ok, 1'b1)
      if (!ref_ok)
         conclude();
      load_speed <= v;
      decel <= d;
      load_stb <= 1'b1;
      @(posedge sys_clk);
      load_stb <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic run_down(input logic [31:0] thr, input logic [13:0] mx, input logic [13:0] lvl);
      int c;
      wr(ADDR_SPEED_THR, thr);
      max_speed <= mx;
      servo_up();
      spin(14'h01f4, 14'h0005);
      servo_on_pin <= 1'b0;
      wait_sig(0, 1'b0, 200, c);
      `CHK(speed < lvl && speed + 14'h000f >= lvl, 1'b1)
   endtask

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      conclude();
   end

   initial
   begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      rd(ADDR_DELAY, 32'h0);
      rd(ADDR_SPEED_THR, 32'h64);
      rd(ADDR_WAIT, 32'h32);
      rd(ADDR_ASSIGN, 32'h0);
      rd(8'h20, 32'h0);
      wr(ADDR_DELAY, 32'h3f);
      rd(ADDR_DELAY, 32'h32);
      wr(ADDR_SPEED_THR, 32'h3fff);
      rd(ADDR_SPEED_THR, 32'h2710);
      wr(ADDR_WAIT, 32'h0);
      rd(ADDR_WAIT, 32'ha);
      wr(ADDR_WAIT, 32'h7f);
      rd(ADDR_WAIT, 32'h64);
      wr(ADDR_DELAY, 32'h0);
      servo_up();
      `CHK(term_out, 3'h0)
      overtravel_pin <= 1'b1;
      repeat (8) @(posedge sys_clk);
      `CHK(brake_release_out, 1'b1)
      rd(ADDR_STATUS, 32'h79);
      overtravel_pin <= 1'b0;
      for (i = 1; i <= 3; i++)
      begin
         servo_on_pin <= 1'b0;
         wait_sig(0, 1'b0, 8, n);
         `CHK(motor_power_en, 1'b0)
         wr(ADDR_ASSIGN, 32'(i));
         rd(ADDR_ASSIGN, 32'(i + 16 * (i - 1)));
         wr(ADDR_CMD, 32'h1);
         servo_up();
         `CHK(term_out, 3'(1 << (i - 1)))
      end
      wr(ADDR_DELAY, 32'h3);
      servo_on_pin <= 1'b0;
      wait_sig(0, 1'b0, 8, n);
      `CHK(motor_power_en, 1'b1)
      wait_sig(1, 1'b0, 60, n);
      `CHK(n >= 3 * TK - 3 && n <= 3 * TK + 3, 1'b1)
      wr(ADDR_DELAY, 32'h32);
      servo_up();
      servo_on_pin <= 1'b0;
      wait_sig(0, 1'b0, 8, n);
      alarm <= 1'b1;
      wait_sig(1, 1'b0, 3, n);
      alarm <= 1'b0;
      wr(ADDR_WAIT, 32'ha);
      wr(ADDR_SPEED_THR, 32'h64);
      servo_up();
      spin(14'h01f4, 14'h0000);
      servo_on_pin <= 1'b0;
      wait_sig(1, 1'b0, 8, n);
      `CHK(brake_release_out, 1'b1)
      wait_sig(0, 1'b0, 120, n);
      `CHK(n >= 10 * TK - 3, 1'b1)
      wr(ADDR_WAIT, 32'h64);
      run_down(32'h12c, 14'h3fff, 14'h012c);
      run_down(32'h2710, 14'h0190, 14'h0190);
      max_speed <= 14'h3fff;
      wr(ADDR_SPEED_THR, 32'h64);
      servo_up();
      spin(14'h01f4, 14'h0000);
      alarm <= 1'b1;
      wait_sig(1, 1'b0, 3, n);
      `CHK(brake_release_out, 1'b1)
      servo_on_pin <= 1'b0;
      wait_sig(0, 1'b0, 1100, n);
      `CHK(n >= 100 * TK - 3, 1'b1)
      alarm <= 1'b0;
      zero_speed_stop <= 1'b1;
      servo_up();
      spin(14'h00c8, 14'h0000);
      alarm <= 1'b1;
      repeat (5) @(posedge sys_clk);
      `CHK({motor_power_en, brake_release_out}, 2'h3)
      spin(14'h0000, 14'h0000);
      wait_sig(0, 1'b0, 4, n);
      `CHK(motor_power_en, 1'b0)
      servo_on_pin <= 1'b0;
      repeat (6) @(posedge sys_clk);
      alarm <= 1'b0;
      servo_up();
      alarm <= 1'b1;
      wait_sig(0, 1'b0, 3, n);
      `CHK(motor_power_en, 1'b0)
      conclude();
   end
endmodule
